// ---- logic/tc8_timer.sv ----
// Top of the 8-bit tick counter with prescaler and overflow flag
`timescale 1ns/1ns
// How it works
// - Eight-bit count advances each instruction cycle
// - Source select zero picks instruction cycles
// - Write blocks counting for two cycles
// - Source select one counts pin edges
// - Edge select picks rising or falling
// - Bypass clear routes prescaler before counter
// - Eight ratios from 1:2 to 1:256
// - Bypass set gives 1:1 rate
// - Prescaler hidden, cleared by count writes
// - Prescaler separate from watchdog prescaler
// - Wrap FFh to 00h sets flag
// - Only software or reset clears the overflow flag
// - Interrupt needs enable and flag set
// - Sleep halts counting, no wake-up
// - Overflow pulse offered as gate
// - Rate code doubles ratio per step
// - Pin edge sampled at Q2, Q4
// - Count held unchanged during sleep except by count writes
module tc8_timer
    import tc8_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic sleep,
    input wire logic external_count_pin,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic overflow_irq,
    output logic overflow_pulse
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Instruction-cycle phases
    // ------------------------------------------------------------
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic icyc_end;
    logic sample_phase;

    assign icyc_end = (phase == 2'(TC8_ICYC_CLKS - 1));
    // Phases 1 and 3 stand for Q2 and Q4
    assign sample_phase = phase[0];

    always_comb begin
        next_phase = icyc_end ? 2'h0 : 2'(phase + 2'h1);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 2'h0;
        end else if (clk_en) begin
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------
    // Configuration and register port
    // ------------------------------------------------------------
    logic [7:0] config_reg;
    logic [7:0] next_config;
    logic irq_en;
    logic next_irq_en;
    logic count_wr;
    logic src_pin;
    logic edge_fall;
    logic bypass;
    logic [2:0] rate;

    assign src_pin = config_reg[TC8_CFG_SRC];
    assign edge_fall = config_reg[TC8_CFG_EDGE];
    assign bypass = config_reg[TC8_CFG_BYP];
    assign rate = config_reg[TC8_CFG_RATE_LO +: 3];
    assign count_wr = reg_write && (reg_addr == TC8_OFS_COUNT);

    always_comb begin
        next_config = config_reg;
        next_irq_en = irq_en;
        if (reg_write && reg_addr == TC8_OFS_CONFIG) begin
            next_config = reg_wdata;
        end
        if (reg_write && reg_addr == TC8_OFS_INTCTL) begin
            next_irq_en = reg_wdata[TC8_IC_EN];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= TC8_CFG_RESET;
            irq_en <= 1'b0;
        end else if (clk_en) begin
            config_reg <= next_config;
            irq_en <= next_irq_en;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronising and edge detection
    // ------------------------------------------------------------
    logic pin_sync;
    logic pin_held;
    logic next_pin_held;
    logic pin_edge;

    tc8_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .enable(clk_en),
        .d(external_count_pin),
        .q(pin_sync)
    );

    // Sampling only at Q2/Q4 limits the pin rate, as documented
    always_comb begin
        next_pin_held = sample_phase ? pin_sync : pin_held;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_held <= 1'b0;
        end else if (clk_en) begin
            pin_held <= next_pin_held;
        end
    end

    // Edge select: 1 = falling, 0 = rising
    assign pin_edge = sample_phase && (pin_sync != pin_held) &&
                      (pin_sync ^ edge_fall);

    // ------------------------------------------------------------
    // Tick source, prescaler and inhibit window
    // ------------------------------------------------------------
    logic run;
    logic src_tick;
    logic pre_term;
    logic advance;
    logic [1:0] inhibit;
    logic [1:0] next_inhibit;

    // Sleep stops advances, prescaler ticks and the inhibit countdown; count writes still act
    assign run = clk_en && !sleep;
    assign src_tick = src_pin ? pin_edge : icyc_end;

    // Private instance; the watchdog keeps its own divider
    tc8_prescaler u_pre (
        .clock(clock),
        .rst_n(rst_n),
        .enable(clk_en),
        .clear(count_wr),
        .tick(run && !bypass && src_tick),
        .rate(rate),
        .terminal(pre_term)
    );

    // Prescaler output or direct tick when bypassed
    assign advance = run && (inhibit == 2'h0) &&
                     (bypass ? src_tick : pre_term);

    // Inhibit counts instruction cycles after a write
    always_comb begin
        next_inhibit = inhibit;
        if (count_wr) begin
            next_inhibit = 2'(TC8_INHIBIT_ICYC);
        end else if (icyc_end && inhibit != 2'h0 && !sleep) begin
            next_inhibit = 2'(inhibit - 2'h1);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inhibit <= 2'h0;
        end else if (clk_en) begin
            inhibit <= next_inhibit;
        end
    end

    // ------------------------------------------------------------
    // Count register and overflow flag
    // ------------------------------------------------------------
    logic [7:0] count_register;
    logic [7:0] next_count;
    logic overflow_flag;
    logic next_flag;
    logic wrap;
    logic next_pulse;

    // A count write overrides the increment, so no rollover then
    assign wrap = advance && !count_wr &&
                  (count_register == TC8_COUNT_MAX);

    always_comb begin
        next_count = count_register;
        next_flag = overflow_flag;
        if (count_wr) begin
            next_count = reg_wdata;
        end else if (advance) begin
            next_count = 8'(count_register + 8'h01);
        end
        if (reg_write && reg_addr == TC8_OFS_INTCTL &&
            !reg_wdata[TC8_IC_FLAG]) begin
            next_flag = 1'b0;
        end
        // Set beats a simultaneous software clear
        if (wrap) begin
            next_flag = 1'b1;
        end
        next_pulse = wrap;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_register <= TC8_COUNT_RESET;
            overflow_flag <= 1'b0;
            overflow_pulse <= 1'b0;
        end else if (clk_en) begin
            count_register <= next_count;
            overflow_flag <= next_flag;
            overflow_pulse <= next_pulse;
        end
    end

    assign overflow_irq = overflow_flag && irq_en;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                TC8_OFS_COUNT: next_rdata = count_register;
                TC8_OFS_CONFIG: next_rdata = config_reg;
                TC8_OFS_INTCTL: begin
                    next_rdata[TC8_IC_EN] = irq_en;
                    next_rdata[TC8_IC_FLAG] = overflow_flag;
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ---- common/tc8_pkg.sv ----
// Package: register map, field layout and timing constants of the tick counter
package tc8_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] TC8_OFS_COUNT = 2'h0;
    localparam logic [1:0] TC8_OFS_CONFIG = 2'h1;
    localparam logic [1:0] TC8_OFS_INTCTL = 2'h2;
    // Config register field positions
    localparam int TC8_CFG_SRC = 5;
    localparam int TC8_CFG_EDGE = 4;
    localparam int TC8_CFG_BYP = 3;
    localparam int TC8_CFG_RATE_LO = 0;
    // Interrupt control field positions
    localparam int TC8_IC_EN = 5;
    localparam int TC8_IC_FLAG = 2;
    // Reset values
    localparam logic [7:0] TC8_CFG_RESET = 8'hFF;
    localparam logic [7:0] TC8_COUNT_RESET = 8'h00;
    // Timing: one instruction cycle in ns, and the clock period
    localparam int TC8_CLK_NS = 20;
    localparam int TC8_ICYC_NS = 80;
    localparam int TC8_ICYC_CLKS = TC8_ICYC_NS / TC8_CLK_NS;
    localparam int TC8_INHIBIT_ICYC = 2;
    localparam logic [7:0] TC8_COUNT_MAX = 8'hFF;
endpackage

// ---- logic/tc8_sync.sv ----
// Two-stage synchroniser for the external count pin
`timescale 1ns/1ns
module tc8_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic d,
    output logic q
);
    logic stage1;
    logic next_stage1;
    logic next_q;

    always_comb begin
        next_stage1 = enable ? d : stage1;
        next_q = enable ? stage1 : q;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            q <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            q <= next_q;
        end
    end
endmodule

// ---- logic/tc8_prescaler.sv ----
// Private 8-bit prescaler with 1:2 to 1:256 terminal count
`timescale 1ns/1ns
module tc8_prescaler
    import tc8_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic clear,
    input wire logic tick,
    input wire logic [2:0] rate,
    output logic terminal
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] limit;

    // Rate 000 divides by 2, each step doubles it
    // Four-bit shift amount, so code 111 really shifts by eight
    assign limit = 8'(({8'h00, 1'b1} << ({1'b0, rate} + 4'h1)) -
                      9'h001);
    // Counter state is never visible outside this module
    assign terminal = tick && (count == limit);

    always_comb begin
        next_count = count;
        if (clear) begin
            next_count = 8'h00;
        end else if (tick) begin
            next_count = (count == limit) ? 8'h00 : 8'(count + 8'h01);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (enable) begin
            count <= next_count;
        end
    end
endmodule

// ---- testbench/tc8_timer_sva.sv ----
// Port checker of the tick counter
`timescale 1ns/1ns
module tc8_timer_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic sleep,
    input wire logic external_count_pin,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic overflow_irq,
    input wire logic overflow_pulse
);
    // ------
    // Properties
    // ------
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_ic_wr;
        reg_write && clk_en && reg_addr == 2'h2;
    endsequence
    sequence s_cnt_wr;
        reg_write && clk_en && reg_addr == 2'h0;
    endsequence
    AST_RD_IDLE: assert property (
        $past(clk_en) && !$past(reg_read) |-> reg_rdata == 8'h00
    ) else $error("read data not idle");
    AST_PULSE_ONE: assert property (
        overflow_pulse && clk_en |=> !overflow_pulse
    ) else $error("overflow pulse too long");
    AST_IRQ_HOLD: assert property (
        overflow_irq && !(reg_write && reg_addr == 2'h2) |=> overflow_irq
    ) else $error("irq dropped without software");
    AST_IRQ_RISE: assert property (
        $rose(overflow_irq)
        |-> overflow_pulse || $past(reg_write && reg_addr == 2'h2)
    ) else $error("irq rose without cause");
    AST_CLR: assert property (
        s_ic_wr ##0 !reg_wdata[2] |=> !overflow_irq || overflow_pulse
    ) else $error("flag clear ignored");
    AST_EN_OFF: assert property (
        s_ic_wr ##0 !reg_wdata[5] |=> !overflow_irq
    ) else $error("irq without enable");
    AST_SLEEP: assert property (
        $past(sleep) && $past(clk_en) |-> !overflow_pulse
    ) else $error("wrap during sleep");
    AST_FROZEN: assert property (
        !clk_en |=> $stable(reg_rdata) && $stable(overflow_pulse)
    ) else $error("outputs moved while frozen");
    AST_INHIBIT: assert property (
        s_cnt_wr |=> !overflow_pulse [*6]
    ) else $error("count advanced inside write window");
endmodule

// ---- testbench/tc8_pin_src.sv ----
// Behavioural external count source on the count pin
`timescale 1ns/1ns
module tc8_pin_src (
    input wire logic clock,
    output logic pin
);
    initial pin = 1'b0;
    // Levels held several clocks so the sampled sync sees each one
    task automatic edges(input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge clock);
            pin <= ~pin;
        end
    endtask
endmodule

// ---- testbench/tc8_timer_tb.sv ----
// Self-checking bench of the tick counter
`timescale 1ns/1ns
module tc8_timer_tb
    import tc8_pkg::*;
;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic sleep = 1'b0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, v, w;
    logic pin, overflow_irq, overflow_pulse;
    int failures = 0;
    int num_checks = 0;
    tc8_timer u_tc8_timer (.clock(clock), .nrst(nrst), .clk_en(clk_en),
        .sleep(sleep), .external_count_pin(pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .overflow_irq(overflow_irq),
        .overflow_pulse(overflow_pulse));
    tc8_pin_src u_tc8_pin_src (.clock(clock), .pin(pin));
    initial begin
        forever #10 clock = ~clock;
    end
    // ------
    // Bus tasks
    // ------
    task automatic chk(input string n, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp=%h got=%h", n, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Advances over exactly n edges, independent of prescaler phase
    task automatic span(input int n, output logic [7:0] d);
        logic [7:0] a;
        rd(TC8_OFS_COUNT, a);
        repeat (n - 2) @(posedge clock);
        rd(TC8_OFS_COUNT, d);
        d = d - a;
    endtask
    task automatic results;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        results();
    end
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd(TC8_OFS_CONFIG, v);
        chk("config", TC8_CFG_RESET, v);
        rd(TC8_OFS_INTCTL, v);
        chk("intctl", 8'h00, v & 8'h24);
        rd(2'h3, v);
        chk("unmapped", 8'h00, v);
        u_tc8_pin_src.edges(3, 6);
        repeat (8) @(posedge clock);
        rd(TC8_OFS_COUNT, v);
        chk("fall", 8'h01, v);
        wr(TC8_OFS_CONFIG, 8'h2F);
        rd(TC8_OFS_COUNT, v);
        u_tc8_pin_src.edges(3, 6);
        repeat (8) @(posedge clock);
        rd(TC8_OFS_COUNT, w);
        chk("rise", 8'h01, w - v);
        wr(TC8_OFS_CONFIG, 8'h20);
        wr(TC8_OFS_COUNT, 8'h00);
        u_tc8_pin_src.edges(8, 10);
        repeat (10) @(posedge clock);
        rd(TC8_OFS_COUNT, v);
        chk("pin_ps", 8'h02, v);
        wr(TC8_OFS_CONFIG, 8'h08);
        wr(TC8_OFS_COUNT, 8'h00);
        repeat (6) @(posedge clock);
        rd(TC8_OFS_COUNT, v);
        chk("inhibit", 8'h00, v);
        span(40, v);
        chk("tick", 8'h0A, v);
        // Written two ahead of FD to make up for the blocked cycles
        wr(TC8_OFS_COUNT, 8'hFF);
        repeat (39) @(posedge clock);
        rd(TC8_OFS_COUNT, v);
        chk("preload", 8'h07, v);
        for (int r = 0; r < 8; r++) begin
            wr(TC8_OFS_CONFIG, 8'(r));
            repeat (4 << (r + 1)) @(posedge clock);
            span(8 << (r + 1), v);
            chk("rate", 8'h02, v);
        end
        wr(TC8_OFS_CONFIG, 8'h08);
        wr(TC8_OFS_INTCTL, 8'h00);
        wr(TC8_OFS_COUNT, 8'hFD);
        for (int i = 0; i < 60 && overflow_pulse !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("wrap", 8'h01, {7'h00, overflow_pulse});
        chk("irq", 8'h00, {7'h00, overflow_irq});
        rd(TC8_OFS_INTCTL, v);
        chk("flag", 8'h04, v & 8'h24);
        wr(TC8_OFS_INTCTL, 8'h24);
        #1 chk("irq", 8'h01, {7'h00, overflow_irq});
        rd(TC8_OFS_INTCTL, v);
        chk("flag", 8'h24, v & 8'h24);
        wr(TC8_OFS_INTCTL, 8'h20);
        #1 chk("irq", 8'h00, {7'h00, overflow_irq});
        rd(TC8_OFS_INTCTL, v);
        chk("flag", 8'h20, v & 8'h24);
        @(posedge clock);
        sleep <= 1'b1;
        rd(TC8_OFS_COUNT, v);
        @(posedge clock);
        clk_en <= 1'b0;
        // Refused while frozen, so the count must not take 55
        wr(TC8_OFS_COUNT, 8'h55);
        clk_en <= 1'b1;
        repeat (40) @(posedge clock);
        rd(TC8_OFS_COUNT, w);
        chk("sleep", v, w);
        @(posedge clock);
        sleep <= 1'b0;
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd(TC8_OFS_CONFIG, v);
        chk("config_rst", TC8_CFG_RESET, v);
        rd(TC8_OFS_COUNT, v);
        chk("count_rst", TC8_COUNT_RESET, v);
        results();
    end
endmodule
bind tc8_timer tc8_timer_chk u_tc8_timer_chk (.clock(clock), .nrst(nrst),
    .clk_en(clk_en), .sleep(sleep), .external_count_pin(external_count_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .overflow_irq(overflow_irq), .overflow_pulse(overflow_pulse));
